/* pds_pkg.sv */
package pds_pkg;

    // Clock and time base.
    localparam int CLK_MHZ   = 125;
    localparam int CNT_MHZ   = 60;
    localparam int TMR_W     = 16;

    // Times in nanoseconds, as specified.
    localparam int T_SETTLE_NS    = 11000;
    localparam int T_CONV_NORM_NS = 33000;
    localparam int T_CONV_CAL_NS  = 26000;
    localparam int T_NARROW_NS    = 700;
    localparam int T_WIDE_NS      = 5000;

    // Least times, rounded up to whole clock cycles.
    localparam int SETTLE_CYC_I    = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_NORM_CYC_I = (T_CONV_NORM_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CAL_CYC_I  = (T_CONV_CAL_NS * CLK_MHZ + 999) / 1000;
    localparam int NARROW_CYC_I    = (T_NARROW_NS * CLK_MHZ + 999) / 1000;
    localparam int WIDE_CYC_I      = (T_WIDE_NS * CLK_MHZ + 999) / 1000;

    localparam logic [TMR_W-1:0] SETTLE_CYC   = TMR_W'(SETTLE_CYC_I);
    localparam logic [TMR_W-1:0] CONV_CAL_CYC = TMR_W'(CONV_CAL_CYC_I);
    localparam logic [TMR_W-1:0] NARROW_CYC   = TMR_W'(NARROW_CYC_I);
    localparam logic [TMR_W-1:0] WIDE_CYC     = TMR_W'(WIDE_CYC_I);

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_TIME_NOW = 8'h08;
    localparam logic [7:0] ADDR_TIME_HIT = 8'h0C;

    // Control register fields and reset.
    localparam int  CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;

    // Host input word fields.
    localparam int IN_PROC_EN_BIT = 15;
    localparam int IN_TUNE_SEL_BIT = 14;
    localparam int IN_WIDE_BIT    = 2;
    localparam int TUNE_W         = 14;

    // Packet sizes.
    localparam logic [2:0] WORDS_NORMAL = 3'h7;
    localparam logic [2:0] WORDS_RF     = 3'h5;
    localparam logic [2:0] WORDS_IF     = 3'h4;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'h0,
        MODE_RF_CAL  = 2'h1,
        MODE_IF_CAL  = 2'h2,
        MODE_STANDBY = 2'h3
    } pds_mode_e;

    typedef enum logic [2:0] {
        CH_AMP   = 3'h0,
        CH_FREQ  = 3'h1,
        CH_PHA   = 3'h2,
        CH_PHB   = 3'h3,
        CH_SIN_A = 3'h4,
        CH_COS_A = 3'h5,
        CH_SIN_B = 3'h6,
        CH_COS_B = 3'h7
    } pds_chan_e;

endpackage : pds_pkg

/* pds_timebase.sv */
`timescale 1ns/10ps
`default_nettype none

interface pds_time_if;
    logic        latch;
    logic [31:0] count;
    logic [31:0] latched;
    modport tb  (input latch, output count, output latched);
    modport seq (output latch, input count, input latched);
endinterface : pds_time_if

module pds_timebase
    import pds_pkg::*;
(
    // Clock and reset.
    input  wire logic hclk,
    input  wire logic hresetn,
    // Time port.
    pds_time_if.tb    tif
);
    typedef struct packed {
        logic [7:0]  acc;
        logic [31:0] count;
        logic [31:0] latched;
    } pds_tb_s;

    pds_tb_s q;
    pds_tb_s d;

    if (CNT_MHZ >= CLK_MHZ) begin : g_bad_rate
        $error("Counter rate must be below the clock rate.");
    end

    // A rate accumulator gives exactly 60 counts per 125 clocks without a
    // second oscillator domain; each step jitters by one clock at most.
    always_comb begin
        d = q;
        if (q.acc + 8'(CNT_MHZ) >= 8'(CLK_MHZ)) begin
            d.acc   = q.acc + 8'(CNT_MHZ) - 8'(CLK_MHZ);
            d.count = q.count + 32'h0000_0001;
        end else begin
            d.acc = q.acc + 8'(CNT_MHZ);
        end
        if (tif.latch) begin
            d.latched = q.count;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tif.count   = q.count;
    assign tif.latched = q.latched;

endmodule : pds_timebase

`default_nettype wire

/* pds_top.sv */
`timescale 1ns/10ps
`default_nettype none

module pds_top
    import pds_pkg::*;
#(
    parameter int T_CONV_NORM_CYC = CONV_NORM_CYC_I
)(
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Receiver discretes.
    input  wire logic        min_threshold_in,
    input  wire logic        adaptive_threshold_detector,
    input  wire logic        accept_in,
    input  wire logic [2:0]  octant_a_in,
    input  wire logic [2:0]  octant_b_in,
    input  wire logic        standby_in,
    output logic             hold_gate,
    output logic             qual_strobe,
    output logic             cal_inject,
    output logic [1:0]       receiver_mode,
    output logic [13:0]      tune_word,
    // Converter.
    output logic             conv_start,
    output logic [2:0]       mux_sel,
    input  wire logic        conv_done,
    input  wire logic [7:0]  conv_data,
    // Host result port.
    output logic [15:0]      out_data,
    output logic             out_ready,
    input  wire logic        out_ack,
    // Host command port.
    input  wire logic [15:0] in_data,
    input  wire logic        in_ready,
    output logic             in_ack
);
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_WIDTH    = 4'h1,
        ST_QUAL     = 4'h2,
        ST_CONV_GO  = 4'h3,
        ST_CONV_WT  = 4'h4,
        ST_CONV_REL = 4'h5,
        ST_CAL_WAIT = 4'h6,
        ST_FINISH   = 4'h7,
        ST_SEND     = 4'h8,
        ST_SEND_ACK = 4'h9,
        ST_SEND_REL = 4'hA
    } pds_state_e;

    typedef struct packed {
        logic        thr;
        logic        det;
        logic        acc;
        logic        done;
        logic [7:0]  cdata;
        logic [2:0]  octa;
        logic [2:0]  octb;
        logic        sby;
        logic        rdy;
        logic [15:0] idata;
        logic        oack;
    } pds_pins_s;

    typedef struct packed {
        pds_pins_s       s1;
        pds_pins_s       s2;
        logic            det_prev;
        pds_state_e      state;
        pds_mode_e       mode;
        pds_mode_e       cyc_mode;
        logic            proc_en;
        logic            wide;
        logic [13:0]     tune;
        logic            run_en;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] since;
        logic            pass2;
        logic [2:0]      idx;
        logic [7:0][7:0] res;
        logic [1:0][7:0] cal_res;
        logic [2:0]      oct_a;
        logic [2:0]      oct_b;
        logic [2:0]      cal_oct_a;
        logic [2:0]      cal_oct_b;
        logic            latch;
        logic            hold;
        logic            qual;
        logic            cal;
        logic            cstart;
        logic [2:0]      msel;
        logic [15:0]     odata;
        logic            ordy;
        logic            iack;
        logic            a_wr;
        logic [7:0]      a_addr;
        logic [31:0]     rdata;
        logic            rdy_o;
    } pds_top_s;

    pds_top_s   q;
    pds_top_s   d;
    pds_time_if tif ();

    if (T_CONV_NORM_CYC >= (1 << TMR_W) || T_CONV_NORM_CYC <= SETTLE_CYC_I) begin : g_bad_conv
        $error("T_CONV_NORM_CYC does not fit the timer or the settle wait.");
    end

    localparam logic [TMR_W-1:0] CONV_NORM_CYC = TMR_W'(T_CONV_NORM_CYC);

    pds_timebase u_timebase (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tif     (tif.tb)
    );

    // Converter channel for a step of the current pass.
    function automatic logic [2:0] chan_of(input pds_mode_e m, input logic p2,
                                           input logic [2:0] i);
        if (m == MODE_IF_CAL) begin
            chan_of = 3'(CH_SIN_A) + i;
        end else if (p2) begin
            chan_of = 3'(CH_PHA) + i;
        end else begin
            chan_of = i;
        end
    endfunction : chan_of

    function automatic logic [2:0] steps_of(input pds_mode_e m, input logic p2);
        steps_of = (m != MODE_IF_CAL && p2) ? 3'h2 : 3'h4;
    endfunction : steps_of

    function automatic logic [2:0] words_of(input pds_mode_e m);
        case (m)
            MODE_NORMAL: words_of = WORDS_NORMAL;
            MODE_RF_CAL: words_of = WORDS_RF;
            default:     words_of = WORDS_IF;
        endcase
    endfunction : words_of

    // Phase words carry the octant code in their top three bits.
    function automatic logic [15:0] phase_word(input logic [2:0] oct, input logic [7:0] v);
        phase_word = {oct, v, 5'h00};
    endfunction : phase_word

    always_comb begin
        pds_pins_s p;
        logic      active;
        logic      det_rise;
        p        = q.s2;
        d        = q;
        d.s1     = '{min_threshold_in, adaptive_threshold_detector, accept_in, conv_done,
                     conv_data, octant_a_in, octant_b_in, standby_in, in_ready, in_data,
                     out_ack};
        d.s2     = q.s1;
        d.det_prev = p.det;
        det_rise = p.det && !q.det_prev;
        d.latch  = 1'b0;
        d.qual   = 1'b0;
        d.cstart = 1'b0;
        d.tmr    = q.tmr + TMR_W'(1);
        d.since  = q.since + TMR_W'(1);
        active   = q.proc_en && q.run_en && !p.sby && q.mode != MODE_STANDBY;

        // Command port: take a word once, hold acknowledge until ready drops.
        if (!q.iack && p.rdy) begin
            d.iack = 1'b1;
            if (p.idata[IN_TUNE_SEL_BIT]) begin
                d.tune = p.idata[TUNE_W-1:0];
            end else begin
                d.proc_en = p.idata[IN_PROC_EN_BIT];
                d.wide    = p.idata[IN_WIDE_BIT];
                d.mode    = pds_mode_e'(p.idata[1:0]);
            end
        end else if (q.iack && !p.rdy) begin
            d.iack = 1'b0;
        end

        case (q.state)
            ST_IDLE: begin
                d.hold = 1'b0;
                d.cal  = 1'b0;
                d.pass2 = 1'b0;
                d.idx  = 3'h0;
                if (!active || q.mode == MODE_NORMAL || d.mode != q.mode) begin
                    d.tmr = '0;
                end
                if (active && q.mode == MODE_NORMAL && p.thr) begin
                    d.state    = ST_WIDTH;
                    d.cyc_mode = q.mode;
                end else if (active && q.mode != MODE_NORMAL && q.tmr >= SETTLE_CYC - 1'b1
                             && d.mode == q.mode) begin
                    d.hold     = 1'b1;
                    d.latch    = (q.mode == MODE_RF_CAL);
                    d.since    = '0;
                    d.oct_a    = p.octa;
                    d.oct_b    = p.octb;
                    d.cyc_mode = q.mode;
                    d.state    = ST_CONV_GO;
                end
            end
            ST_WIDTH: begin
                if (det_rise) begin
                    d.latch = 1'b1;
                end
                if (!p.thr) begin
                    d.state = ST_IDLE;
                end else if (q.tmr >= (q.wide ? WIDE_CYC : NARROW_CYC) - 1'b1) begin
                    d.hold  = 1'b1;
                    d.qual  = 1'b1;
                    d.since = '0;
                    d.oct_a = p.octa;
                    d.oct_b = p.octb;
                    d.state = ST_QUAL;
                end
            end
            ST_QUAL: begin
                if (p.acc) begin
                    d.state = ST_CONV_GO;
                end else begin
                    d.hold  = 1'b0;
                    d.state = ST_IDLE;
                end
            end
            ST_CONV_GO: begin
                d.msel   = chan_of(q.cyc_mode, q.pass2, q.idx);
                d.cstart = 1'b1;
                d.state  = ST_CONV_WT;
            end
            ST_CONV_WT: begin
                if (p.done) begin
                    if (q.pass2 && q.cyc_mode == MODE_NORMAL) begin
                        d.cal_res[q.idx[0]] = p.cdata;
                    end else begin
                        d.res[q.msel] = p.cdata;
                    end
                    d.state = ST_CONV_REL;
                end
            end
            ST_CONV_REL: begin
                if (!p.done) begin
                    if (q.idx != steps_of(q.cyc_mode, q.pass2) - 3'h1) begin
                        d.idx   = q.idx + 3'h1;
                        d.state = ST_CONV_GO;
                    end else if (q.cyc_mode == MODE_NORMAL && !q.pass2) begin
                        d.hold  = 1'b0;
                        d.cal   = 1'b1;
                        d.tmr   = '0;
                        d.state = ST_CAL_WAIT;
                    end else begin
                        d.hold  = 1'b0;
                        d.state = ST_FINISH;
                    end
                end
            end
            ST_CAL_WAIT: begin
                if (q.tmr >= SETTLE_CYC - 1'b1) begin
                    d.hold      = 1'b1;
                    d.pass2     = 1'b1;
                    d.idx       = 3'h0;
                    d.cal_oct_a = p.octa;
                    d.cal_oct_b = p.octb;
                    d.state     = ST_CONV_GO;
                end
            end
            ST_FINISH: begin
                // Conversion complete is held back to the fixed interval so the
                // host sees the same latency whenever the conversions end within that interval.
                if (q.since >= (q.cyc_mode == MODE_NORMAL ? CONV_NORM_CYC : CONV_CAL_CYC)
                               - 1'b1) begin
                    d.cal   = 1'b0;
                    d.idx   = 3'h0;
                    d.state = ST_SEND;
                end
            end
            ST_SEND: begin
                case ({q.cyc_mode == MODE_IF_CAL, q.idx})
                    4'h0:    d.odata = tif.latched[31:16];
                    4'h1:    d.odata = tif.latched[15:0];
                    4'h2:    d.odata = {q.res[CH_AMP], q.res[CH_FREQ]};
                    4'h3:    d.odata = phase_word(q.oct_a, q.res[CH_PHA]);
                    4'h4:    d.odata = phase_word(q.oct_b, q.res[CH_PHB]);
                    4'h5:    d.odata = phase_word(q.cal_oct_a, q.cal_res[0]);
                    4'h6:    d.odata = phase_word(q.cal_oct_b, q.cal_res[1]);
                    default: d.odata = {8'h00, q.res[3'(CH_SIN_A) + q.idx]};
                endcase
                d.ordy  = 1'b1;
                d.state = ST_SEND_ACK;
            end
            ST_SEND_ACK: begin
                if (p.oack) begin
                    d.ordy  = 1'b0;
                    d.state = ST_SEND_REL;
                end
            end
            ST_SEND_REL: begin
                if (!p.oack) begin
                    if (q.idx == words_of(q.cyc_mode) - 3'h1) begin
                        d.tmr   = '0;
                        d.state = ST_IDLE;
                    end else begin
                        d.idx   = q.idx + 3'h1;
                        d.state = ST_SEND;
                    end
                end
            end
            default: d.state = ST_IDLE;
        endcase

        // Register access: one cycle address phase, answer with no wait.
        if (q.a_wr) begin
            if (q.a_addr == ADDR_CTRL) begin
                d.run_en = hwdata[CTRL_RUN_BIT];
            end
        end
        d.a_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            d.a_wr   = hwrite;
            d.a_addr = haddr[7:0];
            case (haddr[7:0])
                ADDR_CTRL:     d.rdata = {31'h0000_0000, q.run_en};
                ADDR_STATUS:   d.rdata = {4'h0, q.tune, 5'h00, p.sby, q.wide, q.proc_en,
                                          q.mode, q.state};
                ADDR_TIME_NOW: d.rdata = tif.count;
                ADDR_TIME_HIT: d.rdata = tif.latched;
                default:       d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q        <= '0;
            q.run_en <= CTRL_RUN_RST;
            q.rdy_o  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign tif.latch     = q.latch;
    assign hrdata        = q.rdata;
    assign hreadyout     = q.rdy_o;
    assign hresp         = 1'b0 & q.rdy_o;
    assign hold_gate     = q.hold;
    assign qual_strobe   = q.qual;
    assign cal_inject    = q.cal;
    assign receiver_mode = q.mode;
    assign tune_word     = q.tune;
    assign conv_start    = q.cstart;
    assign mux_sel       = q.msel;
    assign out_data      = q.odata;
    assign out_ready     = q.ordy;
    assign in_ack        = q.iack;

endmodule : pds_top

`default_nettype wire

/* pds_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module pds_top_chk
    import pds_pkg::*;
(
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Receiver and converter side.
    input wire logic        min_threshold_in,
    input wire logic        hold_gate,
    input wire logic        qual_strobe,
    input wire logic        cal_inject,
    input wire logic [1:0]  receiver_mode,
    input wire logic        conv_start,
    // Host ports.
    input wire logic [15:0] out_data,
    input wire logic        out_ready,
    input wire logic        out_ack,
    input wire logic        in_ready,
    input wire logic        in_ack
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Injection stands too long for a repetition, so it is counted here.
    logic [15:0] inj_q;
    logic [15:0] inj_d;
    assign inj_d = cal_inject ? inj_q + 16'h0001 : 16'h0000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) inj_q <= 16'h0000;
        else inj_q <= inj_d;
    end
    property p_start;
        $rose(hold_gate) && !cal_inject && receiver_mode == MODE_NORMAL |-> $past(min_threshold_in, 10);
    endproperty
    a_start: assert property (p_start) else $error("hold without threshold");
    property p_qual;
        qual_strobe == ($rose(hold_gate) && !cal_inject && receiver_mode == MODE_NORMAL);
    endproperty
    a_qual: assert property (p_qual) else $error("strobe apart from hold");
    property p_conv;
        conv_start |-> hold_gate ##1 !conv_start;
    endproperty
    a_conv: assert property (p_conv) else $error("start outside hold");
    property p_inj;
        $rose(cal_inject) |-> receiver_mode == MODE_NORMAL && !out_ready;
    endproperty
    a_inj: assert property (p_inj) else $error("injection out of turn");
    property p_rehold;
        $rose(hold_gate) && cal_inject |-> inj_q >= SETTLE_CYC - 16'h0004 && inj_q <= SETTLE_CYC + 16'h0004;
    endproperty
    a_rehold: assert property (p_rehold) else $error("second hold mistimed");
    property p_stand;
        out_ready && !out_ack |=> out_ready && $stable(out_data);
    endproperty
    a_stand: assert property (p_stand) else $error("word withdrawn early");
    property p_drop;
        $rose(out_ack) |-> ##[1:6] !out_ready;
    endproperty
    a_drop: assert property (p_drop) else $error("ready held after ack");
    property p_cmd;
        $rose(in_ready) |-> ##[1:6] in_ack;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not acknowledged");
endmodule : pds_top_chk
bind pds_top pds_top_chk i_pds_top_chk (.hclk, .hresetn, .min_threshold_in, .hold_gate,
    .qual_strobe, .cal_inject, .receiver_mode, .conv_start, .out_data, .out_ready,
    .out_ack, .in_ready, .in_ack);
`default_nettype wire

/* pds_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pds_host_model (
    // Clock.
    input wire logic        hclk,
    // Result port.
    input wire logic [15:0] out_data,
    input wire logic        out_ready,
    output logic            out_ack,
    // Command port.
    output logic [15:0]     in_data,
    output logic            in_ready,
    input wire logic        in_ack,
    // Bench side.
    input wire logic [3:0]  ack_delay,
    output logic [15:0]     word,
    output logic            word_got
);
    initial begin
        {out_ack, in_ready, word_got, in_data, word} = '0;
    end
    // A slow host is legal, so the acknowledge waits a chosen count.
    always begin
        @(posedge hclk);
        word_got <= 1'b0;
        if (out_ready === 1'b1 && out_ack === 1'b0) begin
            repeat (ack_delay) @(posedge hclk);
            word <= out_data;
            word_got <= 1'b1;
            out_ack <= 1'b1;
        end else if (out_ready === 1'b0) begin
            out_ack <= 1'b0;
        end
    end
    // Released data is inverted so a stale word cannot look valid.
    task automatic send(input logic [15:0] w);
        @(posedge hclk);
        in_data <= w;
        in_ready <= 1'b1;
        do @(posedge hclk); while (in_ack !== 1'b1);
        in_ready <= 1'b0;
        in_data <= ~w;
        do @(posedge hclk); while (in_ack !== 1'b0);
    endtask : send
endmodule : pds_host_model
`default_nettype wire

/* pds_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", n, e, a); end end
module pds_top_tb
    import pds_pkg::*;
;
    localparam int TN = 2000;
    localparam int TC = CONV_CAL_CYC_I;
    logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout, conv_done;
    logic        min_threshold_in, adaptive_threshold_detector, accept_in;
    logic        standby_in, hold_gate, qual_strobe, cal_inject, conv_start;
    logic        out_ready, out_ack, in_ready, in_ack, word_got, hg_p, or_p;
    logic [1:0]  htrans, receiver_mode;
    logic [2:0]  hsize, mux_sel, octant_a_in, octant_b_in;
    logic [3:0]  ack_delay;
    logic [7:0]  conv_data, cv_base;
    logic [13:0] tune_word, tw;
    logic [15:0] out_data, in_data, word, cur_w;
    logic [15:0] ex [7];
    logic [15:0] got [7];
    logic [31:0] haddr, hwdata, hrdata, rd, t0;
    int          failures, total_checks, nwords, n0, hcnt, lat;
    pds_top #(.T_CONV_NORM_CYC(TN)) i_pds_top (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .min_threshold_in, .adaptive_threshold_detector, .accept_in,
        .octant_a_in, .octant_b_in, .standby_in, .hold_gate, .qual_strobe,
        .cal_inject, .receiver_mode, .tune_word, .conv_start, .mux_sel, .conv_done,
        .conv_data, .out_data, .out_ready, .out_ack, .in_data, .in_ready, .in_ack);
    pds_host_model i_pds_host_model (.hclk, .out_data, .out_ready, .out_ack,
        .in_data, .in_ready, .in_ack, .ack_delay, .word, .word_got);
    always #4 hclk = ~hclk;
    function automatic logic [7:0] cv(input logic [2:0] s);
        return cv_base + {5'h00, s};
    endfunction : cv
    function automatic logic in_rng(input logic [31:0] v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction : in_rng
    // The converter answers late and garbles its data while idle.
    always @(posedge hclk) begin
        if (conv_start === 1'b1) begin
            repeat (2 + $urandom_range(3)) @(posedge hclk);
            conv_data <= cv(mux_sel);
            conv_done <= 1'b1;
            @(posedge hclk);
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
        end
    end
    always @(posedge hclk) begin
        hg_p <= hold_gate;
        or_p <= out_ready;
        hcnt <= (hold_gate && !hg_p && !cal_inject) ? 0 : hcnt + 1;
        if (out_ready && !or_p) lat <= hcnt;
        if (word_got) nwords <= nwords + 1;
    end
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic pulse(input int len, input logic acc);
        accept_in <= acc;
        octant_a_in <= 3'($urandom);
        octant_b_in <= 3'($urandom);
        cv_base <= 8'($urandom);
        min_threshold_in <= 1'b1;
        repeat (12) @(posedge hclk);
        adaptive_threshold_detector <= 1'b1;
        repeat (len) @(posedge hclk);
        {min_threshold_in, adaptive_threshold_detector} <= 2'h0;
        ex[2] = {cv(3'h0), cv(3'h1)};
        ex[3] = {octant_a_in, cv(3'h2), 5'h00};
        ex[4] = {octant_b_in, cv(3'h3), 5'h00};
        ex[5] = ex[3];
        ex[6] = ex[4];
        repeat (20) @(posedge hclk);
    endtask : pulse
    task automatic pkt(input int n, input int t, input int f);
        ack_delay <= 4'(1 + $urandom_range(7));
        for (int i = 0; i < n; i++) begin
            @(posedge hclk iff word_got === 1'b1);
            got[i] = word;
            if (i == 0) `CHK("latency", 1'b1, in_rng(lat, t, t + 40))
            if (i >= f) `CHK("word", ex[i], word)
        end
    endtask : pkt
    task automatic mode(input logic [15:0] w);
        i_pds_host_model.send(cur_w & 16'h7FFF);
        repeat (5000) @(posedge hclk);
        i_pds_host_model.send(w);
        cur_w = w;
        `CHK("mode", w[1:0], receiver_mode)
    endtask : mode
    task automatic conclude();
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (90000) @(posedge hclk);
        failures++;
        conclude();
    end
    initial begin
        {hclk, hresetn, hsel, hwrite, conv_done, standby_in, accept_in} = '0;
        {min_threshold_in, adaptive_threshold_detector, htrans, haddr} = '0;
        {hwdata, conv_data, octant_a_in, octant_b_in, cv_base, cur_w} = '0;
        {failures, total_checks, nwords, hcnt, lat, hg_p, or_p} = '0;
        hsize = 3'h2;
        ack_delay = 4'h1;
        rd = $urandom(78728);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        `CHK("ctrl", 1'b1, rd[CTRL_RUN_BIT])
        ahb(1'b1, 32'h10, 32'hFFFFFFFF);
        ahb(1'b0, 32'h10, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("hresp", 1'b0, hresp)
        tw = 14'($urandom);
        i_pds_host_model.send({2'h1, tw});
        `CHK("tune", tw, tune_word)
        mode(16'h8000);
        ahb(1'b0, 32'(ADDR_TIME_NOW), 32'h0);
        t0 = rd;
        pulse(200, 1'b1);
        n0 = nwords;
        pkt(7, TN, 2);
        `CHK("arrival", 1'b1, in_rng({got[0], got[1]} - t0, 0, 40))
        ahb(1'b0, 32'(ADDR_TIME_HIT), 32'h0);
        `CHK("hit", 1'b1, in_rng(rd - t0, 0, 40))
        // Short, refused and stopped pulses must all leave no packet.
        pulse(40, 1'b1);
        pulse(200, 1'b0);
        ahb(1'b1, 32'h0, 32'h0);
        pulse(200, 1'b1);
        ahb(1'b1, 32'h0, 32'h1);
        mode(16'h8004);
        ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
        `CHK("status mode", 4'hC, rd[7:4])
        `CHK("status tune", tw, rd[27:14])
        pulse(300, 1'b1);
        repeat (2500) @(posedge hclk);
        `CHK("words", n0 + 7, nwords)
        mode(16'h8001);
        repeat (2) pkt(5, TC, 2);
        for (int i = 0; i < 4; i++) ex[i] = {8'h00, cv(3'(4 + i))};
        mode(16'h8002);
        repeat (2) pkt(4, TC, 0);
        mode(16'h8003);
        standby_in <= 1'b1;
        ahb(1'b0, 32'(ADDR_TIME_NOW), 32'h0);
        t0 = rd;
        repeat (1250) @(posedge hclk);
        ahb(1'b0, 32'(ADDR_TIME_NOW), 32'h0);
        `CHK("count", 1'b1, in_rng(rd - t0, 598, 606))
        n0 = nwords;
        pulse(200, 1'b1);
        repeat (2500) @(posedge hclk);
        `CHK("standby", n0, nwords)
        conclude();
    end
endmodule : pds_top_tb
`default_nettype wire
